// *** design/smsp_pkg.sv ***
package smsp_pkg;

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [5:0] SMSP_IDX_CTRL = 6'h0d;
    localparam logic [5:0] SMSP_IDX_STAT = 6'h0e;
    localparam logic [5:0] SMSP_IDX_DATA = 6'h0f;
    localparam logic [5:0] SMSP_IDX_PINS = 6'h10;

    // ------------------------------------------------------------
    // control fields and reset values
    // ------------------------------------------------------------
    localparam int SMSP_B_IRQ_EN = 7;
    localparam int SMSP_B_EN = 6;
    localparam int SMSP_B_ORDER = 5;
    localparam int SMSP_B_MASTER = 4;
    localparam int SMSP_B_CLOCK_POLARITY = 3;
    localparam int SMSP_B_CLOCK_PHASE = 2;
    localparam int SMSP_B_RATE = 0;
    localparam logic [7:0] SMSP_CTRL_RST = 8'h04;

    localparam int SMSP_B_FLAG = 7;
    localparam int SMSP_B_WRITE_COLLISION_FLAG = 6;

    // pin control: direction bits are one for output
    localparam int SMSP_B_DIR_MOSI = 0;
    localparam int SMSP_B_DIR_MISO = 1;
    localparam int SMSP_B_DIR_SCK = 2;
    localparam int SMSP_B_DIR_SS = 3;
    localparam int SMSP_B_SS_LVL = 4;
    localparam logic [7:0] SMSP_PINS_RST = 8'h10;

    // ------------------------------------------------------------
    // half periods of the master clock per rate code
    // ------------------------------------------------------------
    // seven bits wide so that the slowest half period of 64 fits
    localparam logic [6:0] SMSP_HALF_DIV4 = 7'h02;
    localparam logic [6:0] SMSP_HALF_DIV16 = 7'h08;
    localparam logic [6:0] SMSP_HALF_DIV64 = 7'h20;
    localparam logic [6:0] SMSP_HALF_DIV128 = 7'h40;
    localparam logic [4:0] SMSP_EDGES_PER_BYTE = 5'h10;
    localparam logic [3:0] SMSP_BITS_PER_BYTE = 4'h8;

    typedef enum logic {SMSP_IDLE, SMSP_XFER} smsp_state_t;

endpackage : smsp_pkg

// *** design/smsp_clkdiv.sv ***
`timescale 1ns/10ps
module smsp_clkdiv
    import smsp_pkg::*;
(
    // clock and control
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic run,
    input wire logic [1:0] rate,
    // half period pulse
    output logic tick
);

    logic [6:0] cnt_q;
    logic [6:0] cnt_d;
    logic [6:0] half;

    always_comb begin
        case (rate)
            2'b00: half = SMSP_HALF_DIV4;
            2'b01: half = SMSP_HALF_DIV16;
            2'b10: half = SMSP_HALF_DIV64;
            default: half = SMSP_HALF_DIV128;
        endcase
        tick = run && (cnt_q == half - 7'h01);
        cnt_d = (!run || tick) ? 7'h00 : cnt_q + 7'h01;
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cnt_q <= 7'h00;
        end else if (ce) begin
            cnt_q <= cnt_d;
        end
    end

    chk_fast_rate: assert property (@(posedge clk) disable iff (!rst_b)
        (tick && ce && run && rate == 2'b00) ##1 (ce && run && rate == 2'b00) |-> !tick)
        else $error("fastest rate ticked on consecutive cycles");

endmodule : smsp_clkdiv

// *** design/smsp_shifter.sv ***
`timescale 1ns/10ps
module smsp_shifter
    import smsp_pkg::*;
(
    // clock and control
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic lsb_first,
    // load, sample and shift strobes
    input wire logic load,
    input wire logic [7:0] load_val,
    input wire logic sample,
    input wire logic sample_in,
    input wire logic shift,
    // serial out and assembled byte
    output logic out_bit,
    output logic [7:0] rx_word
);

    logic [7:0] sh_q;
    logic [7:0] sh_d;
    logic samp_q;
    logic samp_d;
    logic [7:0] shifted;

    always_comb begin
        // ring step: outgoing bit leaves, sampled bit enters
        shifted = lsb_first ? {samp_q, sh_q[7:1]} : {sh_q[6:0], samp_q};
        rx_word = lsb_first ? {sample_in, sh_q[7:1]} : {sh_q[6:0], sample_in};
        out_bit = lsb_first ? sh_q[0] : sh_q[7];
        samp_d = sample ? sample_in : samp_q;
        sh_d = load ? load_val : (shift ? shifted : sh_q);
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sh_q <= 8'h00;
            samp_q <= 1'b0;
        end else if (ce) begin
            sh_q <= sh_d;
            samp_q <= samp_d;
        end
    end

endmodule : smsp_shifter

// *** design/smsp_top.sv ***
`timescale 1ns/10ps
module smsp_top
    import smsp_pkg::*;
(
    // clock, reset, enable
    input wire logic MCLK,
    input wire logic RST_B,
    input wire logic CE,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // interrupt
    input wire logic GLOBAL_IRQ_EN,
    input wire logic IRQ_ACK,
    output logic IRQ,
    // serial pins, enables low while driving
    input wire logic SCK_I,
    output logic SCK_O,
    output logic SCK_OE_N,
    input wire logic MOSI_I,
    output logic MOSI_O,
    output logic MOSI_OE_N,
    input wire logic MISO_I,
    output logic MISO_O,
    output logic MISO_OE_N,
    input wire logic SS_N_I,
    output logic SS_N_O,
    output logic SS_N_OE_N
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    smsp_state_t state_q, state_d;
    logic [7:0] ctrl_q, ctrl_d;
    logic [7:0] pins_q, pins_d;
    logic [7:0] rxbuf_q, rxbuf_d;
    logic [7:0] rdata_q, rdata_d;
    logic flag_q, flag_d;
    logic write_collision_flag_q, write_collision_flag_d;
    logic arm_flag_q, arm_flag_d;
    logic arm_write_collision_flag_q, arm_write_collision_flag_d;
    logic sck_q, sck_d;
    logic sck_prev_q, sck_prev_d;
    logic [4:0] ntog_q, ntog_d;
    logic [3:0] nsamp_q, nsamp_d;

    // ------------------------------------------------------------
    // decode and events
    // ------------------------------------------------------------
    logic en, master, clock_polarity, clock_phase, order;
    logic setup, access, wr, rd, hit_ctrl, hit_stat, hit_data, hit_pins, mapped;
    logic data_acc, data_wr, busy, fault, slave_act;
    logic tick, edge_ev, lead, sample_ev, shift_ev, last_samp, done_m;
    logic load, out_bit, samp_in;
    logic [7:0] rx_word;

    assign en = ctrl_q[SMSP_B_EN];
    assign master = ctrl_q[SMSP_B_MASTER];
    assign clock_polarity = ctrl_q[SMSP_B_CLOCK_POLARITY];
    assign clock_phase = ctrl_q[SMSP_B_CLOCK_PHASE];
    assign order = ctrl_q[SMSP_B_ORDER];

    always_comb begin
        setup = PSEL && !PENABLE;
        access = PSEL && PENABLE;
        hit_ctrl = PADDR[7:2] == SMSP_IDX_CTRL;
        hit_stat = PADDR[7:2] == SMSP_IDX_STAT;
        hit_data = PADDR[7:2] == SMSP_IDX_DATA;
        hit_pins = PADDR[7:2] == SMSP_IDX_PINS;
        mapped = (hit_ctrl || hit_stat || hit_data || hit_pins) && PADDR[1:0] == 2'b00;
        wr = access && PWRITE && mapped;
        rd = access && !PWRITE && mapped;
        data_acc = access && mapped && hit_data;
        data_wr = wr && hit_data;
        slave_act = en && !master && !SS_N_I;
        busy = (master && state_q == SMSP_XFER) || (!master && nsamp_q != 4'h0);
        // select driven low by another master while we are master
        fault = en && master && !pins_q[SMSP_B_DIR_SS] && !SS_N_I;
        // master edges come from our own divider, slave edges from the pin
        edge_ev = (en && master && state_q == SMSP_XFER) ? tick
                : (slave_act && SCK_I != sck_prev_q);
        lead = edge_ev && ((master ? sck_q : sck_prev_q) == clock_polarity);
        sample_ev = (clock_phase ? (edge_ev && !lead) : lead) && nsamp_q < SMSP_BITS_PER_BYTE;
        shift_ev = (clock_phase ? (lead && nsamp_q != 4'h0) : (edge_ev && !lead))
                 && nsamp_q < SMSP_BITS_PER_BYTE;
        last_samp = sample_ev && nsamp_q == SMSP_BITS_PER_BYTE - 4'h1;
        done_m = master && state_q == SMSP_XFER && tick
               && ntog_q == SMSP_EDGES_PER_BYTE - 5'h01;
        load = data_wr && !busy && en;
        samp_in = master ? MISO_I : MOSI_I;
    end

    smsp_clkdiv smsp_clkdiv_inst (
        .clk(MCLK),
        .rst_b(RST_B),
        .ce(CE),
        .run(en && master && state_q == SMSP_XFER),
        .rate(ctrl_q[SMSP_B_RATE +: 2]),
        .tick(tick)
    );

    smsp_shifter smsp_shifter_inst (
        .clk(MCLK),
        .rst_b(RST_B),
        .ce(CE),
        .lsb_first(order),
        .load(load),
        .load_val(PWDATA[7:0]),
        .sample(sample_ev),
        .sample_in(samp_in),
        .shift(shift_ev),
        .out_bit(out_bit),
        .rx_word(rx_word)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        ctrl_d = ctrl_q;
        pins_d = pins_q;
        rxbuf_d = rxbuf_q;
        flag_d = flag_q;
        write_collision_flag_d = write_collision_flag_q;
        arm_flag_d = arm_flag_q;
        arm_write_collision_flag_d = arm_write_collision_flag_q;
        sck_d = sck_q;
        sck_prev_d = SCK_I;
        ntog_d = ntog_q;
        nsamp_d = nsamp_q;
        rdata_d = rdata_q;

        // read data is captured in setup so the access phase answers
        if (setup) begin
            case (PADDR[7:2])
                SMSP_IDX_CTRL: rdata_d = ctrl_q;
                SMSP_IDX_STAT: rdata_d = {flag_q, write_collision_flag_q, 6'h00};
                SMSP_IDX_DATA: rdata_d = rxbuf_q;
                SMSP_IDX_PINS: rdata_d = pins_q;
                default: rdata_d = 8'h00;
            endcase
        end

        // clears first, so that a same-cycle set below wins
        if (rd && hit_stat) begin
            arm_flag_d = rdata_q[SMSP_B_FLAG];
            arm_write_collision_flag_d = rdata_q[SMSP_B_WRITE_COLLISION_FLAG];
        end
        if (data_acc) begin
            if (arm_flag_q) begin
                flag_d = 1'b0;
            end
            if (arm_write_collision_flag_q) begin
                write_collision_flag_d = 1'b0;
                flag_d = 1'b0;
            end
            arm_flag_d = 1'b0;
            arm_write_collision_flag_d = 1'b0;
        end
        if (IRQ_ACK) begin
            flag_d = 1'b0;
        end
        if (wr && hit_ctrl) begin
            ctrl_d = PWDATA[7:0];
        end
        if (wr && hit_pins) begin
            pins_d = {3'h0, PWDATA[4:0]};
        end
        if (data_wr && busy) begin
            write_collision_flag_d = 1'b1;
        end

        // serial engine
        if (sample_ev) begin
            nsamp_d = nsamp_q + 4'h1;
        end
        if (last_samp) begin
            rxbuf_d = rx_word;
            if (!master) begin
                flag_d = 1'b1;
                nsamp_d = 4'h0;
            end
        end
        case (state_q)
            SMSP_IDLE: begin
                sck_d = clock_polarity;
                ntog_d = 5'h00;
                if (load && master) begin
                    state_d = SMSP_XFER;
                    nsamp_d = 4'h0;
                end else if (load) begin
                    nsamp_d = 4'h0;
                end
            end
            SMSP_XFER: begin
                if (tick) begin
                    sck_d = !sck_q;
                    ntog_d = ntog_q + 5'h01;
                end
                if (done_m) begin
                    state_d = SMSP_IDLE;
                    flag_d = 1'b1;
                    nsamp_d = 4'h0;
                end
            end
            default: state_d = SMSP_IDLE;
        endcase

        if (fault) begin
            ctrl_d[SMSP_B_MASTER] = 1'b0;
            flag_d = 1'b1;
            state_d = SMSP_IDLE;
            nsamp_d = 4'h0;
        end
        if (en && !master && SS_N_I) begin
            nsamp_d = 4'h0;
        end
        if (!en) begin
            state_d = SMSP_IDLE;
            nsamp_d = 4'h0;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            state_q <= SMSP_IDLE;
            ctrl_q <= SMSP_CTRL_RST;
            pins_q <= SMSP_PINS_RST;
            rxbuf_q <= 8'h00;
            rdata_q <= 8'h00;
            flag_q <= 1'b0;
            write_collision_flag_q <= 1'b0;
            arm_flag_q <= 1'b0;
            arm_write_collision_flag_q <= 1'b0;
            sck_q <= 1'b0;
            sck_prev_q <= 1'b0;
            ntog_q <= 5'h00;
            nsamp_q <= 4'h0;
        end else if (CE) begin
            state_q <= state_d;
            ctrl_q <= ctrl_d;
            pins_q <= pins_d;
            rxbuf_q <= rxbuf_d;
            rdata_q <= rdata_d;
            flag_q <= flag_d;
            write_collision_flag_q <= write_collision_flag_d;
            arm_flag_q <= arm_flag_d;
            arm_write_collision_flag_q <= arm_write_collision_flag_d;
            sck_q <= sck_d;
            sck_prev_q <= sck_prev_d;
            ntog_q <= ntog_d;
            nsamp_q <= nsamp_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_comb begin
        PRDATA = {24'h000000, rdata_q};
        PREADY = 1'b1;
        PSLVERR = access && !mapped;
        IRQ = flag_q && ctrl_q[SMSP_B_IRQ_EN] && GLOBAL_IRQ_EN;
        SCK_O = sck_q;
        MOSI_O = out_bit;
        MISO_O = out_bit;
        SS_N_O = pins_q[SMSP_B_SS_LVL];
        // while enabled, mode can only turn a pin into an input; driving still needs its direction bit
        SCK_OE_N = !(pins_q[SMSP_B_DIR_SCK] && !(en && !master));
        MOSI_OE_N = !(pins_q[SMSP_B_DIR_MOSI] && !(en && !master));
        MISO_OE_N = !(pins_q[SMSP_B_DIR_MISO] && !(en && master)
                      && !(en && !master && SS_N_I));
        SS_N_OE_N = !(pins_q[SMSP_B_DIR_SS] && !(en && !master));
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_sck_idle_level: assert property (@(posedge MCLK) disable iff (!RST_B)
        $past(CE && state_q == SMSP_IDLE) && $past(RST_B)
        |-> sck_q == $past(ctrl_q[SMSP_B_CLOCK_POLARITY]))
        else $error("serial clock not at idle level");

    chk_byte_done_flag: assert property (@(posedge MCLK) disable iff (!RST_B)
        CE && done_m && !fault && en |=> flag_q && state_q == SMSP_IDLE)
        else $error("master byte end did not set flag");

    chk_mode_fault_drop: assert property (@(posedge MCLK) disable iff (!RST_B)
        CE && fault |=> !ctrl_q[SMSP_B_MASTER] && flag_q)
        else $error("select fault did not drop master mode");

    chk_collision_set: assert property (@(posedge MCLK) disable iff (!RST_B)
        CE && data_wr && busy |=> write_collision_flag_q)
        else $error("busy data write missed collision flag");

    chk_busy_write_ignored: assert property (@(posedge MCLK) disable iff (!RST_B)
        CE && data_wr && master && state_q == SMSP_XFER && !tick && !fault && en
        |=> state_q == SMSP_XFER && $stable(ntog_q))
        else $error("busy data write disturbed transfer");

    chk_irq_request: assert property (@(posedge MCLK) disable iff (!RST_B)
        CE && done_m && en && !fault ##1 ctrl_q[SMSP_B_IRQ_EN] && GLOBAL_IRQ_EN |-> IRQ)
        else $error("interrupt not raised on flag");

    chk_disabled_idle: assert property (@(posedge MCLK) disable iff (!RST_B)
        CE && !en ##1 CE |-> state_q == SMSP_IDLE && nsamp_q == 4'h0)
        else $error("disabled port kept transferring");

    chk_slave_sck_input: assert property (@(posedge MCLK) disable iff (!RST_B)
        en && !master |-> SCK_OE_N && MOSI_OE_N)
        else $error("slave drove clock or mosi");

    chk_master_miso_in: assert property (@(posedge MCLK) disable iff (!RST_B)
        en && master |-> MISO_OE_N)
        else $error("master drove miso");

    chk_ack_clears: assert property (@(posedge MCLK) disable iff (!RST_B)
        CE && IRQ_ACK && !done_m && !fault && !last_samp |=> !flag_q)
        else $error("vector acknowledge did not clear flag");

    chk_eight_pulses: assert property (@(posedge MCLK) disable iff (!RST_B)
        state_q == SMSP_XFER |-> ntog_q < SMSP_EDGES_PER_BYTE)
        else $error("more than eight clock pulses in a byte");

endmodule : smsp_top

// *** verification/smsp_peer.sv ***
`timescale 1ns/10ps
module smsp_peer
    import smsp_pkg::*;
(
    // serial pins
    input wire logic sck,
    input wire logic mosi,
    input wire logic sel_n,
    output logic miso,
    // frame setup
    input wire logic clock_polarity,
    input wire logic clock_phase,
    input wire logic lsb_first,
    input wire logic [7:0] tx_byte,
    output logic [7:0] rx_byte
);
    // ------------------------------------------------------------
    // behavioural slave on the far side of the link
    // ------------------------------------------------------------
    logic [7:0] sh;
    logic [3:0] n;

    function automatic logic pick(input logic [7:0] v, input logic l);
        return l ? v[0] : v[7];
    endfunction : pick

    // one process owns every output; last seen levels tell the events apart
    initial begin
        logic sel_q;
        logic sck_q;
        miso = 1'b0;
        rx_byte = 8'h00;
        sh = 8'h00;
        n = 4'h0;
        sel_q = 1'b1;
        sck_q = 1'b0;
        forever begin
            @(sel_n or sck);
            if (sel_n !== sel_q) begin
                sel_q = sel_n;
                // released line shows the inverse, not a stale bit
                if (!sel_n) begin
                    sh = tx_byte;
                    n = 4'h0;
                    miso = clock_phase ? ~miso : pick(tx_byte, lsb_first);
                end else begin
                    miso = ~miso;
                end
            end else if (!sel_n && sck !== sck_q) begin
                // ring: each sample shifts our byte out as the master's comes in
                if ((sck != clock_polarity) ^ clock_phase) begin
                    sh = lsb_first ? {mosi, sh[7:1]} : {sh[6:0], mosi};
                    n = n + 4'h1;
                    if (n == 4'h8) begin
                        rx_byte = sh;
                    end
                end else begin
                    miso = pick(sh, lsb_first);
                end
            end
            sck_q = sck;
        end
    end
endmodule : smsp_peer

// *** verification/spi_master_slave_port_test.sv ***
`timescale 1ns/10ps
module spi_master_slave_port_test;
    import smsp_pkg::*;
    // ------------------------------------------------------------
    // stimulus, pins and counters
    // ------------------------------------------------------------
    logic MCLK = 1'b0;
    logic rst_b = 1'b0;
    logic ce = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err_q;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic gie = 1'b1, ack = 1'b0, sck_d = 1'b0, mosi_d = 1'b0, ss_d = 1'b1;
    logic [2:0] mode = 3'h0;
    logic [7:0] peer_tx = 8'h00;
    logic sck_prev;
    wire [31:0] prdata;
    wire [7:0] peer_rx;
    wire pready, pslverr, irq, sck_o, sck_oe_n, mosi_o, mosi_oe_n;
    wire miso_o, miso_oe_n, ss_o, ss_oe_n, peer_miso;
    wire sck_w = sck_oe_n ? sck_d : sck_o;
    wire mosi_w = mosi_oe_n ? mosi_d : mosi_o;
    wire miso_w = miso_oe_n ? peer_miso : miso_o;
    wire ss_w = ss_oe_n ? 1'b1 : ss_o;
    int bad_count = 0;
    int checked = 0;
    int toggles = 0;
    int hv[4] = '{2, 8, 32, 64};

    always #2 MCLK = ~MCLK;

    always @(posedge MCLK) begin
        sck_prev <= sck_o;
        if (sck_o !== sck_prev) begin
            toggles <= toggles + 1;
        end
    end

    smsp_top smsp_top_inst (.MCLK(MCLK), .RST_B(rst_b), .CE(ce), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .GLOBAL_IRQ_EN(gie),
        .IRQ_ACK(ack), .IRQ(irq), .SCK_I(sck_w), .SCK_O(sck_o), .SCK_OE_N(sck_oe_n),
        .MOSI_I(mosi_w), .MOSI_O(mosi_o), .MOSI_OE_N(mosi_oe_n), .MISO_I(miso_w),
        .MISO_O(miso_o), .MISO_OE_N(miso_oe_n), .SS_N_I(ss_d), .SS_N_O(ss_o),
        .SS_N_OE_N(ss_oe_n));

    smsp_peer smsp_peer_inst (.sck(sck_w), .mosi(mosi_w), .sel_n(ss_w), .miso(peer_miso),
        .clock_polarity(mode[1]), .clock_phase(mode[0]), .lsb_first(mode[2]), .tx_byte(peer_tx),
        .rx_byte(peer_rx));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [5:0] a, input logic [7:0] d,
            output logic [7:0] r);
        int k;
        @(posedge MCLK);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {a, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge MCLK);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge MCLK);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) begin
            bad_count++;
            end_of_test();
        end
        r = prdata[7:0];
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
        logic [7:0] r;
        apb(1'b0, a, 8'h00, r);
        chk(r, e);
    endtask : rd_chk

    task automatic wait_irq(output int n);
        n = 0;
        while (irq !== 1'b1) begin
            @(posedge MCLK);
            n++;
            if (n > 20000) begin
                bad_count++;
                end_of_test();
            end
        end
    endtask : wait_irq

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    // m is {order, polarity, phase}
    task automatic master_xfer(input logic [2:0] m, input logic [1:0] rate,
            input logic [7:0] b, input logic [7:0] s);
        int n;
        int t0;
        logic [7:0] r;
        mode = m;
        peer_tx = s;
        apb(1'b1, SMSP_IDX_PINS, 8'h0d, r);
        apb(1'b1, SMSP_IDX_CTRL, {2'b11, m[2], 1'b1, m[1:0], rate}, r);
        // a polarity change settles one edge late in the toggle counter
        repeat (3) @(posedge MCLK);
        chk(sck_o, m[1]);
        t0 = toggles;
        apb(1'b1, SMSP_IDX_DATA, b, r);
        wait_irq(n);
        chk(n >= 16 * hv[rate] && n <= 16 * hv[rate] + 3, 1);
        repeat (2) @(posedge MCLK);
        chk(toggles - t0, 16);
        chk(sck_o, m[1]);
        chk({sck_oe_n, mosi_oe_n, miso_oe_n}, 3'b001);
        chk(peer_rx, b);
        rd_chk(SMSP_IDX_STAT, 8'h80);
        rd_chk(SMSP_IDX_DATA, s);
        rd_chk(SMSP_IDX_STAT, 8'h00);
        chk(irq, 1'b0);
        apb(1'b1, SMSP_IDX_PINS, 8'h1d, r);
    endtask : master_xfer

    task automatic collide();
        int n;
        logic [7:0] r;
        mode = 3'h0;
        peer_tx = 8'h5a;
        apb(1'b1, SMSP_IDX_PINS, 8'h0d, r);
        apb(1'b1, SMSP_IDX_CTRL, 8'hd1, r);
        apb(1'b1, SMSP_IDX_DATA, 8'h3c, r);
        apb(1'b1, SMSP_IDX_DATA, 8'hff, r);
        wait_irq(n);
        repeat (2) @(posedge MCLK);
        rd_chk(SMSP_IDX_STAT, 8'hc0);
        chk(peer_rx, 8'h3c);
        rd_chk(SMSP_IDX_DATA, 8'h5a);
        rd_chk(SMSP_IDX_STAT, 8'h00);
        apb(1'b1, SMSP_IDX_PINS, 8'h1d, r);
    endtask : collide

    task automatic irq_path();
        logic [7:0] r;
        gie <= 1'b0;
        peer_tx = 8'h11;
        apb(1'b1, SMSP_IDX_PINS, 8'h0d, r);
        apb(1'b1, SMSP_IDX_CTRL, 8'hd0, r);
        apb(1'b1, SMSP_IDX_DATA, 8'h81, r);
        repeat (40) @(posedge MCLK);
        chk(irq, 1'b0);
        // a write while the clock enable is low must be lost
        ce <= 1'b0;
        apb(1'b1, SMSP_IDX_CTRL, 8'h00, r);
        ce <= 1'b1;
        rd_chk(SMSP_IDX_CTRL, 8'hd0);
        gie <= 1'b1;
        @(posedge MCLK);
        #1 chk(irq, 1'b1);
        @(posedge MCLK);
        ack <= 1'b1;
        @(posedge MCLK);
        ack <= 1'b0;
        @(posedge MCLK);
        #1 chk(irq, 1'b0);
        rd_chk(SMSP_IDX_STAT, 8'h00);
        apb(1'b1, SMSP_IDX_PINS, 8'h1d, r);
    endtask : irq_path

    task automatic fault_and_off();
        int t0;
        logic [7:0] r;
        apb(1'b1, SMSP_IDX_PINS, 8'h05, r);
        apb(1'b1, SMSP_IDX_CTRL, 8'h50, r);
        ss_d <= 1'b0;
        repeat (4) @(posedge MCLK);
        ss_d <= 1'b1;
        rd_chk(SMSP_IDX_CTRL, 8'h40);
        rd_chk(SMSP_IDX_STAT, 8'h80);
        chk(sck_oe_n, 1'b1);
        apb(1'b0, SMSP_IDX_DATA, 8'h00, r);
        apb(1'b1, SMSP_IDX_CTRL, 8'h50, r);
        rd_chk(SMSP_IDX_CTRL, 8'h50);
        apb(1'b1, SMSP_IDX_CTRL, 8'h10, r);
        t0 = toggles;
        apb(1'b1, SMSP_IDX_DATA, 8'h77, r);
        repeat (40) @(posedge MCLK);
        chk(toggles - t0, 0);
        rd_chk(SMSP_IDX_STAT, 8'h00);
    endtask : fault_and_off

    task automatic slave_rx();
        logic [7:0] r;
        logic [7:0] b = 8'hc3;
        logic [7:0] got = 8'h00;
        apb(1'b1, SMSP_IDX_PINS, 8'h12, r);
        apb(1'b1, SMSP_IDX_CTRL, 8'h40, r);
        apb(1'b1, SMSP_IDX_DATA, 8'ha5, r);
        ss_d <= 1'b0;
        repeat (4) @(posedge MCLK);
        chk(miso_oe_n, 1'b0);
        for (int i = 7; i >= 0; i--) begin
            mosi_d <= b[i];
            repeat (4) @(posedge MCLK);
            got = {got[6:0], miso_o};
            sck_d <= 1'b1;
            repeat (4) @(posedge MCLK);
            sck_d <= 1'b0;
        end
        repeat (4) @(posedge MCLK);
        ss_d <= 1'b1;
        chk(got, 8'ha5);
        rd_chk(SMSP_IDX_STAT, 8'h80);
        rd_chk(SMSP_IDX_DATA, b);
        chk(miso_oe_n, 1'b1);
    endtask : slave_rx

    initial begin
        logic [7:0] r;
        repeat (10) @(posedge MCLK);
        rst_b <= 1'b1;
        rd_chk(SMSP_IDX_CTRL, 8'h04);
        rd_chk(SMSP_IDX_STAT, 8'h00);
        rd_chk(SMSP_IDX_DATA, 8'h00);
        apb(1'b1, SMSP_IDX_STAT, 8'hff, r);
        rd_chk(SMSP_IDX_STAT, 8'h00);
        apb(1'b0, 6'h11, 8'h00, r);
        chk({err_q, r}, 9'h100);
        for (int i = 0; i < 8; i++) begin
            master_xfer(i[2:0], i[1:0], 8'h96 ^ i[7:0], 8'h69 + i[7:0]);
        end
        collide();
        irq_path();
        fault_and_off();
        slave_rx();
        end_of_test();
    end
endmodule : spi_master_slave_port_test
